// ### hw/fpu_state_frame.sv
`timescale 1ns/1ns
`default_nettype none

module fpu_state_frame (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pipeline side
    input  wire logic        unit_busy,       // current instruction in flight
    input  wire logic        fault_kind_dtype,
    input  wire logic [2:0]  fault_vector_in,
    input  wire fpu_exc_pkg::ext_operand_s fault_operand_in,
    output logic             format_error,
    output logic             frame_valid,
    output logic             trap_taken,
    output logic [2:0]       trap_vector,
    output logic             empty_state
);
    // ========================================================================
    // state
    // ========================================================================
    typedef struct packed {
        fpu_exc_pkg::unit_state_e   state;
        logic [2:0]                 vector;
        fpu_exc_pkg::ext_operand_s  operand;
        logic [31:0]                ctrl;
        logic [31:0]                status;
        logic [31:0]                instr_addr;
        logic [fpu_exc_pkg::frame_words-1:0][31:0] frame;
        logic                       save_pending;
        logic                       fmt_err;
        logic                       trap;
        logic [2:0]                 trap_vec;
        logic [31:0]                convert;
        logic [31:0]                conv_res;
        logic                       aw_hold;
        logic [7:0]                 aw_addr;
        logic                       w_hold;
        logic [31:0]                w_data;
        logic [3:0]                 w_strb;
        logic                       bvalid;
        logic                       rvalid;
        logic [31:0]                rdata;
        logic [1:0]                 rresp;
        logic [1:0]                 bresp;
    } regs_s;

    regs_s r;
    regs_s next_r;

    logic [31:0] moved;
    logic        arith_invalid;
    fpu_exc_pkg::int_move_s mv;

    // byte-lane merge of a register write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] st);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = st[i] ? d[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // format code for a state
    function automatic logic [7:0] fmt_of(input fpu_exc_pkg::unit_state_e s);
        unique case (s)
            fpu_exc_pkg::st_empty: fmt_of = fpu_exc_pkg::fmt_empty;
            fpu_exc_pkg::st_idle:  fmt_of = fpu_exc_pkg::fmt_idle;
            fpu_exc_pkg::st_fault: fmt_of = fpu_exc_pkg::fmt_fault;
            default:               fmt_of = fpu_exc_pkg::fmt_empty;
        endcase
    endfunction

    // convert register: [1:0] size, 2 nan, 3 inf, 4 overflow, 5 negative,
    // [18:16] operation for arithmetic check, mantissa high from the operand register
    assign mv = '{valid:    1'b1,
                  size:     r.convert[1:0],
                  is_nan:   r.convert[2],
                  is_inf:   r.convert[3],
                  overflow: r.convert[4],
                  negative: r.convert[5],
                  value:    r.conv_res,
                  mantissa: {r.operand.mantissa}};

    invalid_result u_invalid (
        .op      (r.convert[18:16]),
        .a_inf   (r.convert[19]),
        .a_zero  (r.convert[20]),
        .a_neg   (r.convert[21]),
        .b_inf   (r.convert[22]),
        .b_zero  (r.convert[23]),
        .b_neg   (r.convert[24]),
        .mv      (mv),
        .invalid (arith_invalid),
        .moved   (moved)
    );

    logic aw_take;
    logic w_take;
    logic do_write;
    logic ar_take;
    logic [7:0] fmt_in;

    assign aw_take  = s_axi_awvalid && !r.aw_hold && !r.bvalid;
    assign w_take   = s_axi_wvalid && !r.w_hold && !r.bvalid;
    assign ar_take  = s_axi_arvalid && !r.rvalid;
    assign fmt_in   = r.frame[0][fpu_exc_pkg::fmt_lsb +: 8];

    // ========================================================================
    // next-state logic
    // ========================================================================
    always_comb begin
        logic [7:0]  wa;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        int_fault;
        next_r = r;
        wa = r.aw_hold ? r.aw_addr : s_axi_awaddr;
        wd = r.w_hold ? r.w_data : s_axi_wdata;
        ws = r.w_hold ? r.w_strb : s_axi_wstrb;
        int_fault = 1'b0;
        next_r.trap = 1'b0;
        next_r.fmt_err = 1'b0;
        do_write = 1'b0;
        if (aw_take) begin
            next_r.aw_hold = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (w_take) begin
            next_r.w_hold = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        // write completes when address and data are both present
        if ((r.aw_hold || aw_take) && (r.w_hold || w_take) && !r.bvalid) begin
            do_write = 1'b1;
            next_r.aw_hold = 1'b0;
            next_r.w_hold = 1'b0;
            next_r.bvalid = 1'b1;
            next_r.bresp = 2'b00;
            unique case (wa)
                fpu_exc_pkg::off_ctrl:       next_r.ctrl = merge(r.ctrl, wd, ws);
                fpu_exc_pkg::off_status:     next_r.status = merge(r.status, wd, ws);
                fpu_exc_pkg::off_instr_addr: next_r.instr_addr = merge(r.instr_addr, wd, ws);
                fpu_exc_pkg::off_frame0:     next_r.frame[0] = merge(r.frame[0], wd, ws);
                fpu_exc_pkg::off_frame1:     next_r.frame[1] = merge(r.frame[1], wd, ws);
                fpu_exc_pkg::off_frame2:     next_r.frame[2] = merge(r.frame[2], wd, ws);
                fpu_exc_pkg::off_convert:    next_r.convert = merge(r.convert, wd, ws);
                fpu_exc_pkg::off_conv_res:   next_r.conv_res = merge(r.conv_res, wd, ws);
                fpu_exc_pkg::off_cmd: begin
                    if (wd[fpu_exc_pkg::cmd_save_bit])
                        next_r.save_pending = 1'b1;
                    if (wd[fpu_exc_pkg::cmd_restore_bit]) begin
                        unique case (fmt_in)
                            fpu_exc_pkg::fmt_empty: begin
                                next_r.state = fpu_exc_pkg::st_empty;
                                next_r.ctrl = fpu_exc_pkg::reset_zero;
                                next_r.status = fpu_exc_pkg::reset_zero;
                                next_r.instr_addr = fpu_exc_pkg::reset_zero;
                            end
                            fpu_exc_pkg::fmt_idle: next_r.state = fpu_exc_pkg::st_idle;
                            fpu_exc_pkg::fmt_fault: begin
                                next_r.state = fpu_exc_pkg::st_fault;
                                next_r.vector = r.frame[0][2:0];
                                next_r.operand = '{exponent: r.frame[0][31:16],
                                                   mantissa: {r.frame[1], r.frame[2]}};
                            end
                            default: next_r.fmt_err = 1'b1;
                        endcase
                    end
                    if (wd[fpu_exc_pkg::cmd_instr_bit] &&
                        r.state == fpu_exc_pkg::st_empty)
                        next_r.state = fpu_exc_pkg::st_idle;
                    if (wd[fpu_exc_pkg::cmd_fault_bit]) begin
                        next_r.state = fpu_exc_pkg::st_fault;
                        next_r.vector = fault_kind_dtype ? fault_vector_in : fault_vector_in;
                        next_r.operand = fault_operand_in;
                    end
                end
                default: next_r.bresp = 2'b10; // unmapped: slave error
            endcase
        end
        if (r.bvalid && s_axi_bready)
            next_r.bvalid = 1'b0;

        // integer move out: destination written in the same cycle as the trap
        if (do_write && wa == fpu_exc_pkg::off_convert) begin
            int_fault = wd[2] || wd[3] || wd[4];
            if (wd[1:0] == 2'd3)
                int_fault = 1'b0;
        end
        if (r.convert[7] && r.convert[1:0] != 2'd3) begin
            // one-shot execution of the staged move
            next_r.convert[7] = 1'b0;
            next_r.conv_res = moved;
            if (r.convert[2] || r.convert[3] || r.convert[4]) begin
                next_r.status[fpu_exc_pkg::st_invalid_bit] = 1'b1;
                next_r.status[fpu_exc_pkg::acc_invalid_bit] = 1'b1;
                if (r.ctrl[fpu_exc_pkg::ctrl_invalid_bit]) begin
                    next_r.trap = 1'b1;
                    next_r.trap_vec = fpu_exc_pkg::vec_invalid;
                    next_r.state = fpu_exc_pkg::st_fault;
                    next_r.vector = fpu_exc_pkg::vec_invalid;
                end
            end
        end
        // arithmetic invalid check
        if (r.convert[8]) begin
            next_r.convert[8] = 1'b0;
            if (arith_invalid) begin
                next_r.status[fpu_exc_pkg::st_invalid_bit] = 1'b1;
                next_r.status[fpu_exc_pkg::acc_invalid_bit] = 1'b1;
                next_r.operand = '{exponent: fpu_exc_pkg::qnan_exp,
                                   mantissa: fpu_exc_pkg::qnan_mant};
                if (r.ctrl[fpu_exc_pkg::ctrl_invalid_bit]) begin
                    next_r.trap = 1'b1;
                    next_r.trap_vec = fpu_exc_pkg::vec_invalid;
                end
            end
        end
        // overflow: too-large trap if enabled, else imprecise trap if imprecise enabled
        if (r.convert[9]) begin
            next_r.convert[9] = 1'b0;
            next_r.status[fpu_exc_pkg::st_too_large_bit] = 1'b1;
            next_r.status[fpu_exc_pkg::acc_too_large_bit] = 1'b1;
            next_r.status[fpu_exc_pkg::acc_imprecise_bit] = 1'b1;
            if (!r.ctrl[fpu_exc_pkg::ctrl_too_large_bit] &&
                r.ctrl[fpu_exc_pkg::ctrl_imprecise_bit]) begin
                next_r.trap = 1'b1;
                next_r.trap_vec = fpu_exc_pkg::vec_imprecise;
            end else if (r.ctrl[fpu_exc_pkg::ctrl_too_large_bit]) begin
                next_r.trap = 1'b1;
                next_r.trap_vec = fpu_exc_pkg::vec_too_large;
            end
        end
        // state save once the unit is quiet or stalled on a fault
        if (r.save_pending && (!unit_busy || r.state == fpu_exc_pkg::st_fault)) begin
            next_r.save_pending = 1'b0;
            // operand and vector only carried by fault frames
            if (r.state == fpu_exc_pkg::st_fault) begin
                next_r.frame[0] = {r.operand.exponent, fmt_of(r.state),
                                   5'h00, r.vector};
                next_r.frame[1] = r.operand.mantissa[63:32];
                next_r.frame[2] = r.operand.mantissa[31:0];
                next_r.state = fpu_exc_pkg::st_idle;
            end else begin
                next_r.frame[0] = {16'h0000, fmt_of(r.state), 8'h00};
                next_r.frame[1] = 32'h0000_0000;
                next_r.frame[2] = 32'h0000_0000;
            end
        end
        // reads
        if (ar_take) begin
            next_r.rvalid = 1'b1;
            next_r.rresp = 2'b00;
            unique case (s_axi_araddr)
                fpu_exc_pkg::off_ctrl:       next_r.rdata = r.ctrl;
                fpu_exc_pkg::off_status:     next_r.rdata = r.status;
                fpu_exc_pkg::off_instr_addr: next_r.rdata = r.instr_addr;
                fpu_exc_pkg::off_state:      next_r.rdata = {27'h0, r.save_pending,
                                                             fmt_of(r.state) == 8'h0 ? 1'b0 : 1'b1,
                                                             r.vector};
                fpu_exc_pkg::off_frame0:     next_r.rdata = r.frame[0];
                fpu_exc_pkg::off_frame1:     next_r.rdata = r.frame[1];
                fpu_exc_pkg::off_frame2:     next_r.rdata = r.frame[2];
                fpu_exc_pkg::off_cmd:        next_r.rdata = 32'h0000_0000;
                fpu_exc_pkg::off_convert:    next_r.rdata = r.convert;
                fpu_exc_pkg::off_conv_res:   next_r.rdata = r.conv_res;
                default: begin
                    next_r.rdata = 32'h0000_0000;
                    next_r.rresp = 2'b10;
                end
            endcase
        end
        if (r.rvalid && s_axi_rready)
            next_r.rvalid = 1'b0;
        if (int_fault) begin
            next_r.convert[7] = 1'b1;
        end
    end

    // ========================================================================
    // register
    // ========================================================================
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.state <= fpu_exc_pkg::st_empty;
            r.operand <= '{exponent: fpu_exc_pkg::qnan_exp,
                           mantissa: fpu_exc_pkg::qnan_mant};
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign s_axi_awready = !r.aw_hold && !r.bvalid;
    assign s_axi_wready  = !r.w_hold && !r.bvalid;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = r.bresp;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = r.rresp;
    assign format_error  = r.fmt_err;
    assign frame_valid   = !r.save_pending;
    assign trap_taken    = r.trap;
    assign trap_vector   = r.trap_vec;
    assign empty_state   = r.state == fpu_exc_pkg::st_empty;
endmodule // fpu_state_frame

`default_nettype wire

// ### hw/fpu_exc_pkg.sv
package fpu_exc_pkg;

    // ========================================================================
    // frame formats and vector codes
    // ========================================================================
    localparam logic [7:0] fmt_empty      = 8'h00;
    localparam logic [7:0] fmt_idle       = 8'h60;
    localparam logic [7:0] fmt_fault      = 8'he0;
    localparam int         frame_words    = 3;
    localparam int         fmt_lsb        = 8;
    localparam int         exp_lsb        = 16;

    localparam logic [2:0] vec_unordered  = 3'h0;
    localparam logic [2:0] vec_imprecise  = 3'h1;
    localparam logic [2:0] vec_div_zero   = 3'h2;
    localparam logic [2:0] vec_too_small  = 3'h3;
    localparam logic [2:0] vec_invalid    = 3'h4;
    localparam logic [2:0] vec_too_large  = 3'h5;
    localparam logic [2:0] vec_signaling  = 3'h6;

    // ========================================================================
    // register offsets (axi4-lite byte addresses)
    // ========================================================================
    localparam logic [7:0] off_ctrl       = 8'h00;
    localparam logic [7:0] off_status     = 8'h04;
    localparam logic [7:0] off_instr_addr = 8'h08;
    localparam logic [7:0] off_state      = 8'h0c;
    localparam logic [7:0] off_frame0     = 8'h10;
    localparam logic [7:0] off_frame1     = 8'h14;
    localparam logic [7:0] off_frame2     = 8'h18;
    localparam logic [7:0] off_cmd        = 8'h1c;
    localparam logic [7:0] off_convert    = 8'h20;
    localparam logic [7:0] off_conv_res   = 8'h24;

    // control bit positions (trap enables)
    localparam int ctrl_invalid_bit  = 13;
    localparam int ctrl_too_large_bit = 12;
    localparam int ctrl_imprecise_bit = 9;
    // status bit positions: present byte 15:8, accrued byte 7:0
    localparam int st_invalid_bit    = 13;
    localparam int st_too_large_bit  = 12;
    localparam int acc_invalid_bit   = 7;
    localparam int acc_too_large_bit = 6;
    localparam int acc_imprecise_bit = 3;

    // cmd register bits: 0 save, 1 restore, 2 other instruction, 3 exception
    localparam int cmd_save_bit    = 0;
    localparam int cmd_restore_bit = 1;
    localparam int cmd_instr_bit   = 2;
    localparam int cmd_fault_bit   = 3;

    localparam logic [31:0] reset_zero   = 32'h0000_0000;
    localparam logic [15:0] qnan_exp     = 16'h7fff;
    localparam logic [63:0] qnan_mant    = 64'hffff_ffff_ffff_ffff;
    localparam int          max_kfactor  = 17;
    localparam int          max_exp_dec  = 999;

    typedef enum logic [1:0] {st_empty, st_idle, st_fault} unit_state_e;

    typedef struct packed {
        logic [15:0] exponent;
        logic [63:0] mantissa;
    } ext_operand_s;

    typedef struct packed {
        logic        valid;
        logic [1:0]  size;      // 0 byte, 1 word, 2 long
        logic        is_nan;
        logic        is_inf;
        logic        overflow;
        logic        negative;
        logic [31:0] value;
        logic [63:0] mantissa;
    } int_move_s;

endpackage

// ### hw/invalid_result.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// invalid operand detection and trap-disabled result shaping
// ============================================================================
module invalid_result (
    input  wire logic [2:0]  op,          // 0 add 1 sub 2 mul 3 div 4 root
    input  wire logic        a_inf,
    input  wire logic        a_zero,
    input  wire logic        a_neg,
    input  wire logic        b_inf,
    input  wire logic        b_zero,
    input  wire logic        b_neg,
    input  wire fpu_exc_pkg::int_move_s mv,
    output logic             invalid,
    output logic [31:0]      moved
);
    // largest integer of a size, by sign
    function automatic logic [31:0] sat(input logic [1:0] sz, input logic neg);
        unique case (sz)
            2'd0:    sat = neg ? 32'h0000_0080 : 32'h0000_007f;
            2'd1:    sat = neg ? 32'h0000_8000 : 32'h0000_7fff;
            default: sat = neg ? 32'h8000_0000 : 32'h7fff_ffff;
        endcase
    endfunction

    // arithmetic invalid cases
    always_comb begin
        unique case (op)
            3'd0:    invalid = a_inf && b_inf && (a_neg != b_neg);
            3'd1:    invalid = a_inf && b_inf && (a_neg == b_neg);
            3'd2:    invalid = (a_zero && b_inf) || (a_inf && b_zero);
            3'd3:    invalid = (a_zero && b_zero) || (a_inf && b_inf);
            3'd4:    invalid = a_neg && !a_zero;
            default: invalid = 1'b0;
        endcase
    end

    // integer move-out result
    always_comb begin
        if (mv.is_nan) begin
            unique case (mv.size)
                2'd0:    moved = {24'h0, mv.mantissa[63:56]};
                2'd1:    moved = {16'h0, mv.mantissa[63:48]};
                default: moved = mv.mantissa[63:32];
            endcase
        end else if (mv.is_inf || mv.overflow) begin
            moved = sat(mv.size, mv.negative);
        end else begin
            moved = mv.value;
        end
    end
endmodule // invalid_result

`default_nettype wire

// ### test/fpu_state_frame_props.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bus and state checks at the top ports
// ==========================================
module fpu_state_frame_props (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       s_axi_rready,
    input wire logic [1:0] s_axi_rresp,
    input wire logic       format_error,
    input wire logic       empty_state
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write channels taken together
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_write_answer: assert property (wr_taken |=> s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_one_bresp: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("extra write response");
    a_one_rresp: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("extra read response");
    a_bresp_legal: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
        else $error("bad write response");
    a_rresp_legal: assert property (s_axi_rvalid |-> s_axi_rresp inside {2'h0, 2'h2})
        else $error("bad read response");
    a_fmterr_pulse: assert property (format_error |=> !format_error)
        else $error("format error longer than one cycle");
    a_reset_empty: assert property ($rose(aresetn) |-> empty_state)
        else $error("not empty after reset");
endmodule // fpu_state_frame_props
`default_nettype wire

// ### test/pipe_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// integer pipeline: instruction in flight
// ==========================================
module pipe_model (
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [7:0] len,
    output logic            unit_busy
);
    logic [7:0] left = 8'h00;
    // count down the cycles of the issued instruction
    always @(posedge aclk) begin
        if (go) left <= len;
        else if (left != 8'h00) left <= left - 8'h01;
    end
    assign unit_busy = (left != 8'h00);
endmodule // pipe_model
`default_nettype wire

// ### test/fpu_state_frame_bench.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bench top
// ==========================================
module fpu_state_frame_bench;
    logic        aclk = 0, aresetn = 0, go = 0, seen = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, got, fr [3];
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, busy, ferr, fvalid, empty;
    logic [1:0]  bresp, rresp, gresp;
    logic [2:0]  vec = 0;
    fpu_exc_pkg::ext_operand_s opnd = '0;
    int          n_errors = 0, n_tests = 0, i;
    always #5 aclk = ~aclk;
    // catch the one-cycle format error pulse
    always @(posedge aclk) if (ferr === 1'b1) seen <= 1'b1;
    fpu_state_frame fpu_state_frame_inst (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(got), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .unit_busy(busy), .fault_kind_dtype(1'b0), .fault_vector_in(vec),
        .fault_operand_in(opnd), .format_error(ferr), .frame_valid(fvalid),
        .trap_taken(), .trap_vector(), .empty_state(empty));
    pipe_model pipe_model_inst (.aclk(aclk), .go(go), .len(8'h14), .unit_busy(busy));
    task give_verdict;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        bready <= 0;
        if (i == 100) begin n_errors++; give_verdict; end
    endtask
    task rd(input logic [7:0] a);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        {fr[2], gresp, rready} <= {got, rresp, 1'b0};
        if (i == 100) begin n_errors++; give_verdict; end
        #1;
    endtask
    // wait for the saved frame and read its three words
    task collect;
        for (i = 0; i < 200 && fvalid !== 1'b1; i++) @(posedge aclk);
        if (i == 200) begin n_errors++; give_verdict; end
        rd(fpu_exc_pkg::off_frame0); fr[0] = fr[2];
        rd(fpu_exc_pkg::off_frame1); fr[1] = fr[2];
        rd(fpu_exc_pkg::off_frame2);
    endtask
    task save(input logic [31:0] e0, input logic [31:0] e1, input logic [31:0] e2);
        wr(fpu_exc_pkg::off_cmd, 32'h0000_0001);
        collect;
        chk(fr[0], e0); chk(fr[1], e1); chk(fr[2], e2);
    endtask
    task load(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
        wr(fpu_exc_pkg::off_frame0, w0);
        wr(fpu_exc_pkg::off_frame1, w1);
        wr(fpu_exc_pkg::off_frame2, w2);
        wr(fpu_exc_pkg::off_cmd, 32'h0000_0002);
    endtask
    // ==========================================
    // scenarios
    // ==========================================
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        for (int k = 0; k < 3; k++) begin rd(8'(4 * k)); chk(fr[2], 0); end
        rd(8'h3c); chk(gresp, 2'h2);
        chk(empty, 1);
        wr(fpu_exc_pkg::off_cmd, 32'h0000_0004); chk(empty, 0);
        go <= 1; @(posedge aclk); go <= 0;
        wr(fpu_exc_pkg::off_cmd, 32'h0000_0001); chk(fvalid, 0);
        collect; chk(fr[0][15:0], 16'h6000);
        {vec, opnd} <= {3'h5, 16'h1234, 64'h89ab_cdef_0123_4567};
        wr(fpu_exc_pkg::off_cmd, 32'h0000_0008);
        save(32'h1234_e005, 32'h89ab_cdef, 32'h0123_4567);
        wr(fpu_exc_pkg::off_cmd, 32'h0000_0001); collect; chk(fr[0][15:8], 8'h60);
        load(32'h0000_2000, 0, 0); repeat (4) @(posedge aclk); chk(seen, 1);
        load(32'h5555_e004, 32'haaaa_5555, 32'h1357_9bdf);
        save(32'h5555_e004, 32'haaaa_5555, 32'h1357_9bdf);
        load(0, 0, 0); chk(empty, 1);
        save(0, 0, 0);
        wr(fpu_exc_pkg::off_convert, 32'h0000_0028);
        rd(fpu_exc_pkg::off_conv_res); chk(fr[2], 32'h0000_0080);
        wr(fpu_exc_pkg::off_convert, 32'h0148_0100);
        rd(fpu_exc_pkg::off_status); chk(fr[2], 32'h0000_2080);
        give_verdict;
    end
endmodule // fpu_state_frame_bench
bind fpu_state_frame fpu_state_frame_props fpu_state_frame_props_inst (.*);
`default_nettype wire
